// file: hw/isdrc_pkg.sv
package isdrc_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ACC_FAST_PERIOD_NS = 625000;
  localparam int unsigned ACC_FAST_CYC = ACC_FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned GYR_FAST_PERIOD_NS = 500000;
  localparam int unsigned GYR_FAST_CYC = GYR_FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned GYR_IRQ_MIN_NS = 280000;
  localparam int unsigned GYR_IRQ_CYC =
    (GYR_IRQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SRST_DELAY_NS = 1000;
  localparam logic [7:0] SRST_CYC = 8'(SRST_DELAY_NS / CLK_PERIOD_NS);
  localparam int unsigned BIST_NS = 10000;
  localparam logic [15:0] BIST_CYC = 16'(BIST_NS / CLK_PERIOD_NS);
  localparam int unsigned ST_SETUP_NS = 2000000;
  localparam int unsigned ST_SETUP_CYC = ST_SETUP_NS / CLK_PERIOD_NS + 1;
  localparam int unsigned ST_SETTLE_NS = 50000000;
  localparam int unsigned ST_SETTLE_CYC = ST_SETTLE_NS / CLK_PERIOD_NS + 1;
  // ==========================================================
  // Accelerometer map
  localparam logic [7:0] A_STATUS = 8'h03;
  localparam logic [7:0] A_DATA_LO = 8'h12;
  localparam logic [7:0] A_INT_STAT = 8'h1D;
  localparam logic [7:0] A_CONF = 8'h40;
  localparam logic [7:0] A_RANGE = 8'h41;
  localparam logic [7:0] A_MAP = 8'h58;
  localparam logic [7:0] A_SELFTEST = 8'h6D;
  localparam logic [7:0] A_SOFTRESET = 8'h7E;
  localparam logic [7:0] A_CONF_RST = 8'hA8;
  localparam logic [7:0] A_RANGE_RST = 8'h01;
  localparam logic [3:0] ACC_ODR_MIN = 4'h5;
  localparam logic [3:0] ACC_ODR_MAX = 4'hC;
  localparam int DRDY_BIT = 7;
  localparam int BWP_LSB = 4;
  localparam int ST_EN_BIT = 0;
  localparam int ST_POS_BIT = 2;
  localparam int A_MAP_PA_BIT = 2;
  localparam int A_MAP_PB_BIT = 6;
  // ==========================================================
  // Gyroscope map
  localparam logic [7:0] G_DATA_LO = 8'h06;
  localparam logic [7:0] G_BW = 8'h10;
  localparam logic [7:0] G_SOFTRESET = 8'h14;
  localparam logic [7:0] G_INT_CTRL = 8'h15;
  localparam logic [7:0] G_MAP = 8'h18;
  localparam logic [7:0] G_SELFTEST = 8'h3C;
  localparam logic [7:0] G_BW_RST = 8'h80;
  localparam int G_MAP_PA_BIT = 0;
  localparam int G_MAP_PB_BIT = 7;
  localparam int BIST_TRIG_BIT = 0;
  localparam int BIST_RDY_BIT = 1;
  localparam int BIST_FAIL_BIT = 2;
  localparam int BIST_OK_BIT = 4;
  // ==========================================================
  // Commands and self-test values
  localparam logic [7:0] SOFTRESET_CMD = 8'hB6;
  localparam logic [7:0] G_DRDY_EN = 8'h80;
  localparam logic [7:0] ST_RANGE_VAL = 8'h03;
  localparam logic [7:0] ST_CONF_VAL = 8'hA7;
  localparam logic [7:0] ST_POS_VAL = 8'h0D;
  localparam logic [7:0] ST_NEG_VAL = 8'h09;
  localparam logic [7:0] ST_OFF_VAL = 8'h00;
  localparam int RANGE16_MG = 16000;
  localparam int ST_LIM_XY_MG = 1000;
  localparam int ST_LIM_Z_MG = 500;
  localparam logic signed [16:0] ST_LIM_XY = 17'(ST_LIM_XY_MG * 32768 / RANGE16_MG);
  localparam logic signed [16:0] ST_LIM_Z = 17'(ST_LIM_Z_MG * 32768 / RANGE16_MG);
  localparam logic signed [15:0] ST_OFFSET_DEF = 16'sh1000;
  // ==========================================================
  // Host registers
  localparam logic [3:0] H_CMD = 4'h0;
  localparam logic [3:0] H_STATUS = 4'h4;
  localparam logic [3:0] H_START = 4'h8;
endpackage

// file: hw/isdrc_if.sv
`timescale 1ns/1ps
interface isdrc_if;
  logic reqValid;
  logic reqGyro;
  logic reqWrite;
  logic [7:0] reqAddr;
  logic [7:0] reqData;
  logic rspValid;
  logic [7:0] rspData;
  logic accIrqA;
  logic accIrqB;
  logic gyroIrqA;
  logic gyroIrqB;
  modport dev(input reqValid, reqGyro, reqWrite, reqAddr, reqData,
    output rspValid, rspData, accIrqA, accIrqB, gyroIrqA, gyroIrqB);
  modport host(output reqValid, reqGyro, reqWrite, reqAddr, reqData,
    input rspValid, rspData, accIrqA, accIrqB, gyroIrqA, gyroIrqB);
endinterface

// file: hw/isdrc_sensor_dev.sv
`timescale 1ns/1ps
// ==========================================================
// Notes on behaviour
// - Accel filter depth follows bandwidth field
// - Accel config holds rate and bandwidth
// - Gyro offers eight rate/bandwidth settings
// - Host sets range, config, waits 2 ms
// - Host applies positive test, waits, reads
// - Host applies negative test, waits, reads
// - Host ends test, waits 50 ms
// - Pass needs x,y 1000 mg, z 500 mg
// - Self-test adds static offset to output
// - Host resets accel after self-test
// - Gyro test: trigger, ready, fail bit
// - Gyro background check reads bit 4
// - Accel new-data flag set, auto-cleared
// - Accel new-data routable to two pins
// - Gyro new-data pulse 280-400 us
// - Host enables gyro new-data with 0x80
// - Gyro new-data routable to two pins
// - Reset command restores defaults after delay
// - Eight-bit registers, eight-bit addresses
// - Separate maps, selected per sensor
// - Host writes unused bits as zero
// - Low byte read freezes high byte
// - Data read clears accel ready flag
module isdrc_sensor_dev
  import isdrc_pkg::*;
#(
  parameter int unsigned ACC_BASE_CYC = ACC_FAST_CYC,
  parameter int unsigned GYR_BASE_CYC = GYR_FAST_CYC,
  parameter int unsigned GYR_IRQ_LEN = GYR_IRQ_CYC,
  parameter logic signed [15:0] ST_OFFSET = ST_OFFSET_DEF
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic bistFault,
  isdrc_if.dev link
);
  // ==========================================================
  // Parameter checks
  if (ACC_BASE_CYC < 2 || ACC_BASE_CYC > 131071) begin : gBadAcc
    $error("accel base period out of range");
  end
  if (GYR_IRQ_LEN < 1 || GYR_IRQ_LEN >= GYR_BASE_CYC || GYR_BASE_CYC > 800000) begin : gBadGyr
    $error("gyro timing out of range");
  end

  // ==========================================================
  // Decoding
  function automatic logic [23:0] accPeriod(input logic [3:0] odr);
    logic [3:0] o;
    o = (odr < ACC_ODR_MIN) ? ACC_ODR_MIN : ((odr > ACC_ODR_MAX) ? ACC_ODR_MAX : odr);
    return 24'(ACC_BASE_CYC << (ACC_ODR_MAX - o)) - 24'h1;
  endfunction

  function automatic logic [23:0] gyrPeriod(input logic [2:0] bw);
    logic [4:0] f;
    case (bw)
      3'h0, 3'h1: f = 5'd1;
      3'h2: f = 5'd2;
      3'h3: f = 5'd5;
      3'h4, 3'h6: f = 5'd10;
      default: f = 5'd20;
    endcase
    return 24'(GYR_BASE_CYC * f) - 24'h1;
  endfunction

  logic rd, wr, wrA, wrG;
  assign rd = link.reqValid && !link.reqWrite;
  assign wr = link.reqValid && link.reqWrite;
  assign wrA = wr && !link.reqGyro;
  assign wrG = wr && link.reqGyro;

  // ==========================================================
  // Configuration and soft reset
  logic [7:0] aConf_q, aRange_q, aSt_q, aMap_q, gBw_q, gInt_q, gMap_q;
  logic [7:0] aSrst_q, gSrst_q;
  logic aCfgRst, gCfgRst;
  assign aCfgRst = (aSrst_q == 8'h01);
  assign gCfgRst = (gSrst_q == 8'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aSrst_q <= 8'h00;
      gSrst_q <= 8'h00;
    end else if (ce) begin
      if (wrA && link.reqAddr == A_SOFTRESET && link.reqData == SOFTRESET_CMD) begin
        aSrst_q <= SRST_CYC;
      end else if (aSrst_q != 8'h00) begin
        aSrst_q <= aSrst_q - 8'h01;
      end
      if (wrG && link.reqAddr == G_SOFTRESET && link.reqData == SOFTRESET_CMD) begin
        gSrst_q <= SRST_CYC;
      end else if (gSrst_q != 8'h00) begin
        gSrst_q <= gSrst_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aConf_q <= A_CONF_RST;
      aRange_q <= A_RANGE_RST;
      aSt_q <= 8'h00;
      aMap_q <= 8'h00;
    end else if (ce) begin
      if (aCfgRst) begin
        aConf_q <= A_CONF_RST;
        aRange_q <= A_RANGE_RST;
        aSt_q <= 8'h00;
        aMap_q <= 8'h00;
      end else if (wrA) begin
        if (link.reqAddr == A_CONF) aConf_q <= link.reqData;
        if (link.reqAddr == A_RANGE) aRange_q <= link.reqData;
        if (link.reqAddr == A_SELFTEST) aSt_q <= link.reqData;
        if (link.reqAddr == A_MAP) aMap_q <= link.reqData;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gBw_q <= G_BW_RST;
      gInt_q <= 8'h00;
      gMap_q <= 8'h00;
    end else if (ce) begin
      if (gCfgRst) begin
        gBw_q <= G_BW_RST;
        gInt_q <= 8'h00;
        gMap_q <= 8'h00;
      end else if (wrG) begin
        if (link.reqAddr == G_BW) gBw_q <= link.reqData;
        if (link.reqAddr == G_INT_CTRL) gInt_q <= link.reqData;
        if (link.reqAddr == G_MAP) gMap_q <= link.reqData;
      end
    end
  end

  // ==========================================================
  // Accelerometer sampling
  logic [23:0] aCnt_q;
  logic [15:0] aSeq_q;
  logic aTick;
  logic [1:0] shiftK;
  logic signed [15:0] stOfs;
  logic signed [15:0] aData_q [3];
  logic [7:0] aShadow_q [3];
  assign aTick = (aCnt_q == 24'h0);
  // Deeper averaging lowers the cutoff at a given rate
  assign shiftK = (aConf_q[6:4] == 3'd1) ? 2'd1 : ((aConf_q[6:4] == 3'd0) ? 2'd2 : 2'd0);
  assign stOfs = !aSt_q[ST_EN_BIT] ? 16'sh0000 :
                 (aSt_q[ST_POS_BIT] ? ST_OFFSET : -ST_OFFSET);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aCnt_q <= 24'h0;
      aSeq_q <= 16'h0;
    end else if (ce) begin
      aCnt_q <= aTick ? accPeriod(aConf_q[3:0]) : aCnt_q - 24'h1;
      if (aTick) aSeq_q <= aSeq_q + 16'h1;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : gAxis
    logic signed [15:0] raw;
    logic signed [16:0] diff;
    logic [7:0] loAddr;
    // Z deflects less, so its offset is halved
    assign raw = $signed(aSeq_q + 16'(i * 1024)) + ((i == 2) ? (stOfs >>> 1) : stOfs);
    assign diff = 17'(raw) - 17'(aData_q[i]);
    assign loAddr = A_DATA_LO + 8'(2 * i);
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        aData_q[i] <= 16'sh0;
        aShadow_q[i] <= 8'h00;
      end else if (ce) begin
        if (aTick) aData_q[i] <= aData_q[i] + 16'(diff >>> shiftK);
        if (rd && !link.reqGyro && link.reqAddr == loAddr) begin
          aShadow_q[i] <= aData_q[i][15:8];
        end
      end
    end
  end

  // ==========================================================
  // Accelerometer new-data flag
  logic aDrdy_q, dataRd;
  assign dataRd = rd && !link.reqGyro && link.reqAddr >= A_DATA_LO &&
                  link.reqAddr < A_DATA_LO + 8'h06;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aDrdy_q <= 1'b0;
    end else if (ce) begin
      if (aTick) aDrdy_q <= 1'b1;
      else if (dataRd) aDrdy_q <= 1'b0;
    end
  end

  // ==========================================================
  // Gyroscope sampling, new-data pulse and test
  logic [23:0] gCnt_q;
  logic [15:0] gZ_q, gIrq_q, gBist_q;
  logic [7:0] gShadow_q;
  logic gTick, gRdy_q, gFail_q, gOk_q;
  assign gTick = (gCnt_q == 24'h0);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gCnt_q <= 24'h0;
      gZ_q <= 16'h0;
      gShadow_q <= 8'h00;
      gIrq_q <= 16'h0;
    end else if (ce) begin
      gCnt_q <= gTick ? gyrPeriod(gBw_q[2:0]) : gCnt_q - 24'h1;
      if (gTick) gZ_q <= gZ_q - 16'h3;
      if (rd && link.reqGyro && link.reqAddr == G_DATA_LO) gShadow_q <= gZ_q[15:8];
      if (gTick && gInt_q[DRDY_BIT]) gIrq_q <= 16'(GYR_IRQ_LEN);
      else if (gIrq_q != 16'h0) gIrq_q <= gIrq_q - 16'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gBist_q <= 16'h0;
      gRdy_q <= 1'b0;
      gFail_q <= 1'b0;
      gOk_q <= 1'b0;
    end else if (ce) begin
      gOk_q <= !bistFault;
      if (wrG && link.reqAddr == G_SELFTEST && link.reqData[BIST_TRIG_BIT]) begin
        gBist_q <= BIST_CYC;
        gRdy_q <= 1'b0;
      end else if (gBist_q == 16'h1) begin
        gBist_q <= 16'h0;
        gRdy_q <= 1'b1;
        gFail_q <= bistFault;
      end else if (gBist_q != 16'h0) begin
        gBist_q <= gBist_q - 16'h1;
      end
    end
  end

  // ==========================================================
  // Read answer and pins
  logic [7:0] rdVal;
  always_comb begin
    rdVal = 8'h00;
    if (!link.reqGyro) begin
      case (link.reqAddr)
        A_STATUS, A_INT_STAT: rdVal = {aDrdy_q, 7'h00};
        A_DATA_LO: rdVal = aData_q[0][7:0];
        A_DATA_LO + 8'h1: rdVal = aShadow_q[0];
        A_DATA_LO + 8'h2: rdVal = aData_q[1][7:0];
        A_DATA_LO + 8'h3: rdVal = aShadow_q[1];
        A_DATA_LO + 8'h4: rdVal = aData_q[2][7:0];
        A_DATA_LO + 8'h5: rdVal = aShadow_q[2];
        A_CONF: rdVal = aConf_q;
        A_RANGE: rdVal = aRange_q;
        A_SELFTEST: rdVal = aSt_q;
        A_MAP: rdVal = aMap_q;
        default: rdVal = 8'h00;
      endcase
    end else begin
      case (link.reqAddr)
        G_DATA_LO: rdVal = gZ_q[7:0];
        G_DATA_LO + 8'h1: rdVal = gShadow_q;
        G_BW: rdVal = gBw_q;
        G_INT_CTRL: rdVal = gInt_q;
        G_MAP: rdVal = gMap_q;
        G_SELFTEST: rdVal = {3'b000, gOk_q, 1'b0, gFail_q, gRdy_q, 1'b0};
        default: rdVal = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.rspValid <= 1'b0;
      link.rspData <= 8'h00;
      link.accIrqA <= 1'b0;
      link.accIrqB <= 1'b0;
      link.gyroIrqA <= 1'b0;
      link.gyroIrqB <= 1'b0;
    end else if (ce) begin
      link.rspValid <= link.reqValid;
      link.rspData <= rd ? rdVal : 8'h00;
      link.accIrqA <= aDrdy_q && aMap_q[A_MAP_PA_BIT];
      link.accIrqB <= aDrdy_q && aMap_q[A_MAP_PB_BIT];
      link.gyroIrqA <= (gIrq_q != 16'h0) && gMap_q[G_MAP_PA_BIT];
      link.gyroIrqB <= (gIrq_q != 16'h0) && gMap_q[G_MAP_PB_BIT];
    end
  end
endmodule

// file: hw/isdrc_host_ctrl.sv
`timescale 1ns/1ps
module isdrc_host_ctrl
  import isdrc_pkg::*;
#(
  parameter int unsigned SETUP_CYC = ST_SETUP_CYC,
  parameter int unsigned SETTLE_CYC = ST_SETTLE_CYC
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWritedata,
  output logic [31:0] avReaddata,
  output logic avWaitrequest,
  isdrc_if.host link
);
  if (SETUP_CYC < 2 || SETTLE_CYC < 2 || SETTLE_CYC > 32'h0FFF_FFFF) begin : gBad
    $error("self-test wait out of range");
  end

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_RUN = 5'b00010, S_LINK = 5'b00100,
    S_WAIT = 5'b01000, S_EVAL = 5'b10000
  } isdrc_state_t;
  typedef enum logic [2:0] {
    OP_WR, OP_WS, OP_WL, OP_RD, OP_EV, OP_END
  } isdrc_op_t;

  // ==========================================================
  // Self-test program: {op, gyro, addr, data}
  function automatic logic [19:0] stepOp(input logic [3:0] idx);
    case (idx)
      4'h0: return {OP_WR, 1'b0, A_RANGE, ST_RANGE_VAL};
      4'h1: return {OP_WR, 1'b0, A_CONF, ST_CONF_VAL};
      4'h2: return {OP_WS, 1'b0, 8'h00, 8'h00};
      4'h3: return {OP_WR, 1'b0, A_SELFTEST, ST_POS_VAL};
      4'h4: return {OP_WL, 1'b0, 8'h00, 8'h00};
      4'h5: return {OP_RD, 1'b0, A_DATA_LO, 8'h00};
      4'h6: return {OP_WR, 1'b0, A_SELFTEST, ST_NEG_VAL};
      4'h7: return {OP_WL, 1'b0, 8'h00, 8'h00};
      4'h8: return {OP_RD, 1'b0, A_DATA_LO, 8'h06};
      4'h9: return {OP_WR, 1'b0, A_SELFTEST, ST_OFF_VAL};
      4'hA: return {OP_WL, 1'b0, 8'h00, 8'h00};
      4'hB: return {OP_EV, 1'b0, 8'h00, 8'h00};
      4'hC: return {OP_WR, 1'b0, A_SOFTRESET, SOFTRESET_CMD};
      4'hD: return {OP_WR, 1'b1, G_INT_CTRL, G_DRDY_EN};
      default: return {OP_END, 1'b0, 8'h00, 8'h00};
    endcase
  endfunction

  isdrc_state_t st_q;
  logic [3:0] pc_q;
  logic [2:0] byteIdx_q;
  logic [27:0] wait_q;
  logic [7:0] buf_q [12];
  logic stPass_q, stDone_q, avPend_q, cmdIssued_q;
  logic [19:0] cur;
  isdrc_op_t curOp;
  logic seqIssue, cmdHit, cmdIssue;
  assign cur = stepOp(pc_q);
  assign curOp = isdrc_op_t'(cur[19:17]);
  assign seqIssue = (st_q == S_RUN) && (curOp == OP_WR || curOp == OP_RD);
  assign cmdHit = avWrite && avAddress == H_CMD && avWaitrequest;
  assign cmdIssue = cmdHit && st_q == S_IDLE && !cmdIssued_q && !avPend_q;

  // ==========================================================
  // Signed 17-bit difference per axis against the limits
  function automatic logic axisOk(input int a, input logic signed [16:0] lim);
    logic signed [16:0] d;
    d = 17'($signed({buf_q[a + 1], buf_q[a]})) -
        17'($signed({buf_q[a + 7], buf_q[a + 6]}));
    return d >= lim;
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      pc_q <= 4'h0;
      byteIdx_q <= 3'h0;
      wait_q <= 28'h0;
      stPass_q <= 1'b0;
      stDone_q <= 1'b0;
      for (int i = 0; i < 12; i++) buf_q[i] <= 8'h00;
    end else if (ce) begin
      case (st_q)
        S_IDLE: begin
          if (avWrite && !avWaitrequest && avAddress == H_START && avWritedata[0]) begin
            st_q <= S_RUN;
            pc_q <= 4'h0;
            stDone_q <= 1'b0;
            stPass_q <= 1'b0;
          end
        end
        S_RUN: begin
          case (curOp)
            OP_WR, OP_RD: st_q <= S_LINK;
            OP_WS: begin
              wait_q <= 28'(SETUP_CYC);
              st_q <= S_WAIT;
            end
            OP_WL: begin
              wait_q <= 28'(SETTLE_CYC);
              st_q <= S_WAIT;
            end
            OP_EV: st_q <= S_EVAL;
            default: begin
              st_q <= S_IDLE;
              stDone_q <= 1'b1;
            end
          endcase
        end
        S_LINK: begin
          if (link.rspValid) begin
            st_q <= S_RUN;
            if (curOp == OP_RD) begin
              // Ascending reads fetch each low byte before its high byte
              buf_q[cur[3:0] + 4'(byteIdx_q)] <= link.rspData;
              byteIdx_q <= (byteIdx_q == 3'h5) ? 3'h0 : byteIdx_q + 3'h1;
              if (byteIdx_q == 3'h5) pc_q <= pc_q + 4'h1;
            end else begin
              pc_q <= pc_q + 4'h1;
            end
          end
        end
        S_WAIT: begin
          wait_q <= wait_q - 28'h1;
          if (wait_q == 28'h1) begin
            st_q <= S_RUN;
            pc_q <= pc_q + 4'h1;
          end
        end
        S_EVAL: begin
          stPass_q <= axisOk(0, ST_LIM_XY) && axisOk(2, ST_LIM_XY) && axisOk(4, ST_LIM_Z);
          pc_q <= pc_q + 4'h1;
          st_q <= S_RUN;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Link driver: the sequencer owns the link while it runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.reqValid <= 1'b0;
      link.reqGyro <= 1'b0;
      link.reqWrite <= 1'b0;
      link.reqAddr <= 8'h00;
      link.reqData <= 8'h00;
    end else if (ce) begin
      link.reqValid <= seqIssue || cmdIssue;
      if (seqIssue) begin
        link.reqGyro <= cur[16];
        link.reqWrite <= curOp == OP_WR;
        link.reqAddr <= cur[15:8] + ((curOp == OP_RD) ? 8'(byteIdx_q) : 8'h00);
        link.reqData <= (curOp == OP_WR) ? cur[7:0] : 8'h00;
      end else if (cmdIssue) begin
        link.reqGyro <= avWritedata[16];
        link.reqWrite <= !avWritedata[17];
        link.reqAddr <= avWritedata[15:8];
        link.reqData <= avWritedata[7:0];
      end
    end
  end

  // ==========================================================
  // Avalon slave; a command write stalls until the link answers
  logic [7:0] lastRd_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avWaitrequest <= 1'b1;
      avReaddata <= 32'h0;
      avPend_q <= 1'b0;
      cmdIssued_q <= 1'b0;
      lastRd_q <= 8'h00;
    end else if (ce) begin
      avWaitrequest <= 1'b1;
      if (cmdIssue) cmdIssued_q <= 1'b1;
      if (cmdIssued_q && link.rspValid) begin
        lastRd_q <= link.rspData;
        cmdIssued_q <= 1'b0;
        avPend_q <= 1'b1;
      end
      if (!avWaitrequest) begin
        avPend_q <= 1'b0;
      end else if ((avRead || avWrite) && (avAddress != H_CMD || !avRead) &&
                   (avAddress != H_CMD || avPend_q || !avWrite)) begin
        avWaitrequest <= 1'b0;
        avReaddata <= 32'h0;
        if (avRead && avAddress == H_STATUS) begin
          avReaddata <= {17'h0, stPass_q, stDone_q, st_q != S_IDLE, link.gyroIrqB,
                         link.gyroIrqA, link.accIrqB, link.accIrqA, lastRd_q};
        end
      end else if (avRead && avAddress == H_CMD) begin
        avWaitrequest <= 1'b0;
        avReaddata <= {31'h0, cmdIssued_q};
      end
    end
  end
endmodule

// file: tb/isdrc_monitor.sv
`timescale 1ns/1ps
module isdrc_monitor
  import isdrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic reqValid,
  input wire logic reqGyro,
  input wire logic reqWrite,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqData,
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic accIrqA,
  input wire logic accIrqB,
  input wire logic gyroIrqA,
  input wire logic gyroIrqB
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ========
  // Helpers
  logic gyroEn_q;
  wire logic srst = reqValid && reqWrite && reqData == SOFTRESET_CMD;
  wire logic accRd = reqValid && !reqWrite && !reqGyro && reqAddr >= A_DATA_LO
    && reqAddr <= 8'h17;
  // Kept over soft reset, so a late pulse never looks unenabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gyroEn_q <= 1'b0;
    end else if (reqValid && reqWrite && reqGyro && reqAddr == G_INT_CTRL) begin
      gyroEn_q <= reqData[7];
    end
  end
  // ========
  // Properties
  sequence s_req; reqValid; endsequence
  sequence s_ans; rspValid && !reqValid; endsequence
  sequence s_hold; gyroIrqA[*8]; endsequence
  property p_answer; s_req |=> s_ans; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_orphan; rspValid |-> $past(reqValid); endproperty
  a_orphan: assert property (p_orphan) else $error("stray answer");
  property p_wrZero; s_req ##0 reqWrite |=> rspData == 8'h00; endproperty
  a_wrZero: assert property (p_wrZero) else $error("write data");
  property p_rdClear; accRd |-> ##[1:2] !accIrqA && !accIrqB; endproperty
  a_rdClear: assert property (p_rdClear) else $error("flag kept");
  property p_gyroLen; $rose(gyroIrqA) |-> s_hold ##[10:14] !gyroIrqA; endproperty
  a_gyroLen: assert property (p_gyroLen) else $error("pulse length");
  property p_gyroEn; $rose(gyroIrqA) || $rose(gyroIrqB) |-> gyroEn_q; endproperty
  a_gyroEn: assert property (p_gyroEn) else $error("pulse not enabled");
  property p_accSrst; srst && !reqGyro && reqAddr == A_SOFTRESET |-> ##[40:43] !accIrqA; endproperty
  a_accSrst: assert property (p_accSrst) else $error("accel reset");
  property p_gyrSrst; srst && reqGyro && reqAddr == G_SOFTRESET |-> ##[40:62] !gyroIrqA; endproperty
  a_gyrSrst: assert property (p_gyrSrst) else $error("gyro reset");
endmodule

// file: tb/tb_imu_selftest_drdy_reset_ctrl.sv
`timescale 1ns/1ps
module tb_imu_selftest_drdy_reset_ctrl
  import isdrc_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, avRead = 1'b0, avWrite = 1'b0, bistFault = 1'b0, avWaitrequest;
  logic [3:0] avAddress = 4'h0;
  logic ce = 1'b1;
  logic [31:0] avWritedata = 32'h0, avReaddata, s;
  logic [7:0] r8 = 8'h06;
  int err_count = 0, comparisons = 0, cyc = 0;
  int mdl[int];
  isdrc_if lnk();
  isdrc_sensor_dev #(.ACC_BASE_CYC(50), .GYR_BASE_CYC(60), .GYR_IRQ_LEN(20)) u_isdrc_sensor_dev (
    .clk(clk), .nrst(nrst), .ce(ce), .bistFault(bistFault), .link(lnk.dev));
  isdrc_host_ctrl #(.SETUP_CYC(20), .SETTLE_CYC(5000)) u_isdrc_host_ctrl (.clk(clk),
    .nrst(nrst), .ce(ce), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avWritedata(avWritedata), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
    .link(lnk.host));
  isdrc_monitor u_isdrc_monitor (.clk(clk), .nrst(nrst), .reqValid(lnk.reqValid),
    .reqGyro(lnk.reqGyro), .reqWrite(lnk.reqWrite), .reqAddr(lnk.reqAddr), .reqData(lnk.reqData),
    .rspValid(lnk.rspValid), .rspData(lnk.rspData), .accIrqA(lnk.accIrqA),
    .accIrqB(lnk.accIrqB), .gyroIrqA(lnk.gyroIrqA), .gyroIrqB(lnk.gyroIrqB));
  // ========
  // Bus tasks
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avRead <= !w;
    avWrite <= w;
    avAddress <= a;
    avWritedata <= d;
    do @(posedge clk); while (avWaitrequest !== 1'b0);
    s = avReaddata;
    avRead <= 1'b0;
    avWrite <= 1'b0;
  endtask
  // Status read after each command leaves the byte in s[7:0]
  task automatic rg(input logic g, input logic [7:0] a, input logic [7:0] d, input logic rd);
    av(1'b1, H_CMD, {14'h0, rd, g, a, d});
    if (!rd) mdl[{g, a}] = d;
    av(1'b0, H_STATUS, 32'h0);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ========
  // Clock, limit and sequence
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    mdl[A_CONF] = A_CONF_RST;
    mdl[A_RANGE] = A_RANGE_RST;
    mdl[{1'b1, G_BW}] = G_BW_RST;
    foreach (mdl[k]) begin
      rg(k[8], k[7:0], 8'h00, 1'b1);
      chk(s[7:0], mdl[k]);
    end
    for (int i = 0; i < 8; i++) begin
      r8 = lfsr(r8);
      rg(1'b0, A_CONF, {2'h2, (r8[5:4] == 2'h3) ? 2'h2 : r8[5:4], 4'h5 + {1'b0, r8[2:0]}}, 1'b0);
      rg(1'b0, A_CONF, 8'h00, 1'b1);
      chk(s[7:0], mdl[A_CONF]);
      rg(1'b1, G_BW, 8'h80 | 8'(i), 1'b0);
      rg(1'b1, G_BW, 8'h00, 1'b1);
      chk(s[7:0], mdl[{1'b1, G_BW}]);
    end
    av(1'b0, 4'hC, 32'h0);
    chk(s, 32'h0);
    $display("test config done");
    for (int f = 0; f < 2; f++) begin
      bistFault <= f[0];
      rg(1'b1, G_SELFTEST, 8'h01, 1'b0);
      // Frozen while the link is idle, so the test must not finish
      ce <= 1'b0;
      repeat (410) @(posedge clk);
      ce <= 1'b1;
      rg(1'b1, G_SELFTEST, 8'h00, 1'b1);
      chk(s[1], 1'b0);
      repeat (410) @(posedge clk);
      rg(1'b1, G_SELFTEST, 8'h00, 1'b1);
      chk({s[4], s[2], s[1]}, {!f[0], f[0], 1'b1});
    end
    bistFault <= 1'b0;
    rg(1'b1, G_SOFTRESET, SOFTRESET_CMD, 1'b0);
    repeat (45) @(posedge clk);
    rg(1'b1, G_BW, 8'h00, 1'b1);
    chk(s[7:0], G_BW_RST);
    $display("test gyro test and reset done");
    rg(1'b0, A_CONF, A_CONF_RST, 1'b0);
    rg(1'b0, A_MAP, 8'h44, 1'b0);
    do av(1'b0, H_STATUS, 32'h0); while (s[8] !== 1'b1);
    rg(1'b0, A_INT_STAT, 8'h00, 1'b1);
    chk({s[9:8], s[7]}, 3'b111);
    rg(1'b0, A_DATA_LO, 8'h00, 1'b1);
    chk(s[9:8], 2'b00);
    rg(1'b1, G_MAP, 8'h81, 1'b0);
    rg(1'b1, G_INT_CTRL, G_DRDY_EN, 1'b0);
    do av(1'b0, H_STATUS, 32'h0); while (s[10] !== 1'b1);
    chk(s[11], 1'b1);
    $display("test new data done");
    av(1'b1, H_START, 32'h1);
    do av(1'b0, H_STATUS, 32'h0); while (s[13] !== 1'b1);
    chk(s[14:12], 3'b110);
    // Soft reset lands only after its delay
    repeat (45) @(posedge clk);
    rg(1'b0, A_CONF, 8'h00, 1'b1);
    chk(s[7:0], A_CONF_RST);
    $display("test self-test done");
    tally_and_finish();
  end
endmodule
